// [hdl/eam_alarm_monitor.sv]
// Top of the E1 alarm monitor: registers, tick, clock of day, slips and alarm grading.
// Assumes error and slip pulses come from logic on mclk; the board switch is a pin.
// Overview of operation
// RL1 - Below minor threshold: no alarm, outputs idle.
// RL2 - Minor: close contact, light LED, log.
// RL3 - Major: minor actions plus conditioning and yellow.
// RL4 - Conditioning presents all channels per board switch.
// RL5 - Threshold digit 3 to 9, else invalid.
// RL6 - Digit n means error ratio ten^-n.
// RL7 - Duration limited per digit, max 3600.
// RL8 - Duration 1 to 3600 seconds before alarm.
// RL9 - Error counter saturates at 65,000.
// RL10 - Software sets major digit below minor.
// RL11 - Self-clear drops indications, else hold.
// RL12 - Clearing reopens contact, LED off, logs.
// RL13 - Supervision ends when condition ceases anyway.
// RL14 - Declare as soon as count exceeded.
// RL15 - Activation resets counter, fresh window.
// RL16 - Clear only after full quiet window.
// RL17 - Slips above threshold raise major alarm.
// RL18 - Slip period 1 to 24 hours, reset.
// RL19 - Defaults: minor digit 6, major 5.
// RL20 - Defaults: 10 second durations.
// RL21 - Defaults: slip threshold 5, two hours.
// RL22 - Keep 24-hour time and date.
// RL23 - Manual clear resets alarms and counters.
// RL24 - Self-clearing enabled by default.
// RL25 - One-second tick; reset clears counters.
// RL26 - Minor and major monitored independently.
`timescale 1ns/1ps
`default_nettype none
module eam_alarm_monitor
    import eam_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic bitErr,
    input wire logic frameSlip,
    input wire logic offHookSwitch,
    output logic alarmContact,
    output logic redLed,
    output logic lineCond,
    output logic chanOffHook,
    output logic yellowAlarm,
    output logic logValid,
    output eam_log_t logEntry,
    output eam_level_t alarmLevel
);
    localparam int DIV_W = $clog2(TICK_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic tick;
        logic sw1;
        logic sw2;
        eam_ber_cfg_t minCfg;
        eam_ber_cfg_t majCfg;
        logic [7:0] slipThr;
        logic [4:0] slipHrs;
        logic selfClr;
        logic badParam;
        logic clrPulse;
        eam_time_t tod;
        eam_date_t date;
        logic [11:0] secOfHour;
        logic [4:0] hourCnt;
        logic [8:0] slipCnt;
        logic slipCond;
        eam_level_t ind;
        logic lineCond;
        logic [31:0] rdata;
        logic logValid;
        eam_log_t logEntry;
    } eam_top_state_t;

    eam_top_state_t st_ff, nxt_st;
    logic minCond, majCond;
    eam_level_t curLvl;
    logic [4:0] monthDays;

    // The two bit-error monitors run side by side with their own windows.
    eam_ber_window u_minor ( // RL26
        .mclk(mclk),
        .rst(rst),
        .tick(st_ff.tick),
        .errPulse(bitErr),
        .clr(st_ff.clrPulse),
        .cfg(st_ff.minCfg),
        .cond(minCond),
        .raise()
    );

    eam_ber_window u_major (
        .mclk(mclk),
        .rst(rst),
        .tick(st_ff.tick),
        .errPulse(bitErr),
        .clr(st_ff.clrPulse),
        .cfg(st_ff.majCfg),
        .cond(majCond),
        .raise()
    );

    // Validity checks on configuration writes.
    function automatic logic cfg_ok(input eam_ber_cfg_t c);
        cfg_ok = (c.digit >= DIG_MIN) && (c.digit <= DIG_MAX) // RL5
            && (c.dur >= eam_dur_min(c.digit)) // RL7
            && (c.dur <= eam_dur_max(c.digit)); // RL8
    endfunction

    // Rank of a level, for comparison.
    function automatic logic [1:0] rank(input eam_level_t l);
        case (l)
            LVL_MAJOR: rank = 2'h2;
            LVL_MINOR: rank = 2'h1;
            default: rank = 2'h0;
        endcase
    endfunction

    // Highest level currently detected by any monitor.
    always_comb begin
        if (majCond || st_ff.slipCond) begin
            curLvl = LVL_MAJOR;
        end else if (minCond) begin
            curLvl = LVL_MINOR;
        end else begin
            curLvl = LVL_NONE; // RL1
        end
    end

    // Days in the current month, with every fourth year a leap year.
    always_comb begin
        case (st_ff.date.mon)
            4'h2: monthDays = (st_ff.date.yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: monthDays = 5'h1E;
            default: monthDays = 5'h1F;
        endcase
    end

    // Next state of everything the top holds.
    always_comb begin
        eam_ber_cfg_t wcfg;
        eam_time_t wt;
        eam_date_t wd;
        wcfg = regWdata[15:0];
        wt = regWdata[16:0];
        wd = regWdata[15:0];
        nxt_st = st_ff;
        nxt_st.logValid = 1'b0;
        nxt_st.clrPulse = 1'b0;
        nxt_st.sw1 = offHookSwitch;
        nxt_st.sw2 = st_ff.sw1;

        // One-second tick divider.
        nxt_st.tick = 1'b0;
        if (st_ff.div == DIV_LAST) begin
            nxt_st.div = '0;
            nxt_st.tick = 1'b1; // RL25
        end else begin
            nxt_st.div = st_ff.div + DIV_W'(1);
        end

        // Clock of day and calendar.
        if (st_ff.tick) begin
            nxt_st.tod.ss = st_ff.tod.ss + 6'h01; // RL22
            if (st_ff.tod.ss == MIN_PER_HOUR - 6'h01) begin
                nxt_st.tod.ss = '0;
                nxt_st.tod.mm = st_ff.tod.mm + 6'h01;
                if (st_ff.tod.mm == MIN_PER_HOUR - 6'h01) begin
                    nxt_st.tod.mm = '0;
                    nxt_st.tod.hh = st_ff.tod.hh + 5'h01;
                    if (st_ff.tod.hh == HOURS_PER_DAY - 5'h01) begin
                        nxt_st.tod.hh = '0;
                        nxt_st.date.day = st_ff.date.day + 5'h01;
                        if (st_ff.date.day >= monthDays) begin
                            nxt_st.date.day = 5'h01;
                            nxt_st.date.mon = st_ff.date.mon + 4'h1;
                            if (st_ff.date.mon == 4'hC) begin
                                nxt_st.date.mon = 4'h1;
                                nxt_st.date.yr = (st_ff.date.yr == 7'h63) ? 7'h00
                                    : st_ff.date.yr + 7'h01;
                            end
                        end
                    end
                end
            end
        end

        // Frame slip counting over a period of whole hours.
        if (frameSlip && st_ff.slipCnt != 9'h1FF) begin
            nxt_st.slipCnt = st_ff.slipCnt + 9'h001;
        end
        if (nxt_st.slipCnt > {1'b0, st_ff.slipThr}) begin
            nxt_st.slipCond = 1'b1; // RL17
        end
        if (st_ff.tick) begin
            nxt_st.secOfHour = st_ff.secOfHour + 12'h001;
            if (st_ff.secOfHour == SECS_PER_HOUR - 12'h001) begin
                nxt_st.secOfHour = '0;
                nxt_st.hourCnt = st_ff.hourCnt + 5'h01;
                if (st_ff.hourCnt + 5'h01 >= st_ff.slipHrs) begin
                    nxt_st.hourCnt = '0;
                    nxt_st.slipCnt = '0; // RL18
                    nxt_st.slipCond = 1'b0;
                end
            end
        end

        // Register writes; a bad value is refused and flagged.
        if (regWr) begin
            case (regAddr)
                REG_CTRL: begin
                    nxt_st.selfClr = regWdata[CTRL_SELFCLR];
                    nxt_st.clrPulse = regWdata[CTRL_CLEAR];
                end
                REG_MINOR: begin
                    if (cfg_ok(wcfg)) begin
                        nxt_st.minCfg = wcfg;
                    end else begin
                        nxt_st.badParam = 1'b1; // RL5
                    end
                end
                REG_MAJOR: begin
                    if (cfg_ok(wcfg)) begin
                        nxt_st.majCfg = wcfg;
                    end else begin
                        nxt_st.badParam = 1'b1;
                    end
                end
                REG_SLIP: begin
                    if (regWdata[7:0] != 8'h00 && regWdata[12:8] != 5'h00
                        && regWdata[12:8] <= SLIP_HRS_MAX) begin
                        nxt_st.slipThr = regWdata[7:0];
                        nxt_st.slipHrs = regWdata[12:8];
                    end else begin
                        nxt_st.badParam = 1'b1;
                    end
                end
                REG_STATUS: begin
                    if (regWdata[STAT_BADPARAM]) begin
                        nxt_st.badParam = 1'b0;
                    end
                end
                REG_TIME: begin
                    if (wt.hh < HOURS_PER_DAY && wt.mm < MIN_PER_HOUR
                        && wt.ss < MIN_PER_HOUR) begin
                        nxt_st.tod = wt;
                    end else begin
                        nxt_st.badParam = 1'b1;
                    end
                end
                REG_DATE: begin
                    if (wd.mon != 4'h0 && wd.mon <= 4'hC && wd.day != 5'h00
                        && wd.yr <= 7'h63) begin
                        nxt_st.date = wd;
                    end else begin
                        nxt_st.badParam = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Manual clear also drops the slip condition and counters.
        if (st_ff.clrPulse) begin
            nxt_st.slipCnt = '0; // RL23
            nxt_st.slipCond = 1'b0;
            nxt_st.hourCnt = '0;
            nxt_st.secOfHour = '0;
        end

        // Alarm grading: rise at once, fall by self-clear or manual clear.
        nxt_st.logEntry.tod = st_ff.tod;
        nxt_st.logEntry.date = st_ff.date;
        if (st_ff.clrPulse) begin
            nxt_st.ind = LVL_NONE; // RL23
            if (st_ff.ind != LVL_NONE) begin
                nxt_st.logValid = 1'b1; // RL12
                nxt_st.logEntry.cleared = 1'b1;
                nxt_st.logEntry.level = st_ff.ind;
            end
        end else if (rank(curLvl) > rank(st_ff.ind)) begin
            nxt_st.ind = curLvl; // RL2
            nxt_st.logValid = 1'b1;
            nxt_st.logEntry.cleared = 1'b0;
            nxt_st.logEntry.level = curLvl;
        end else if (st_ff.selfClr && rank(curLvl) < rank(st_ff.ind)) begin
            nxt_st.ind = curLvl; // RL11
            nxt_st.logValid = 1'b1; // RL12
            nxt_st.logEntry.cleared = 1'b1;
            nxt_st.logEntry.level = st_ff.ind;
        end

        // Line conditioning follows the major condition itself.
        nxt_st.lineCond = (curLvl == LVL_MAJOR) && !st_ff.clrPulse; // RL13

        // Read data, returned in the cycle after the strobe.
        nxt_st.rdata = '0;
        if (regRd) begin
            case (regAddr)
                REG_CTRL: nxt_st.rdata[CTRL_SELFCLR] = st_ff.selfClr;
                REG_MINOR: nxt_st.rdata[15:0] = st_ff.minCfg;
                REG_MAJOR: nxt_st.rdata[15:0] = st_ff.majCfg;
                REG_SLIP: nxt_st.rdata[12:0] = {st_ff.slipHrs, st_ff.slipThr};
                REG_STATUS: nxt_st.rdata = {7'h00, st_ff.slipCnt, 12'h000, st_ff.badParam,
                    st_ff.ind};
                REG_TIME: nxt_st.rdata[16:0] = st_ff.tod;
                REG_DATE: nxt_st.rdata[15:0] = st_ff.date;
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    // State register with factory defaults.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0; // RL25
            st_ff.minCfg <= '{digit: DEF_MINOR_DIG, dur: DEF_DUR}; // RL19
            st_ff.majCfg <= '{digit: DEF_MAJOR_DIG, dur: DEF_DUR}; // RL20
            st_ff.slipThr <= DEF_SLIP_THR; // RL21
            st_ff.slipHrs <= DEF_SLIP_HRS;
            st_ff.selfClr <= 1'b1; // RL24
            st_ff.ind <= LVL_NONE;
            st_ff.logEntry.level <= LVL_NONE;
            st_ff.date <= '{mon: 4'h1, day: 5'h01, yr: 7'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register.
    assign alarmContact = st_ff.ind != LVL_NONE; // RL2
    assign redLed = st_ff.ind != LVL_NONE;
    assign lineCond = st_ff.lineCond; // RL3
    assign yellowAlarm = st_ff.lineCond;
    assign chanOffHook = st_ff.lineCond && st_ff.sw2; // RL4
    assign logValid = st_ff.logValid;
    assign logEntry = st_ff.logEntry;
    assign alarmLevel = st_ff.ind;
    assign regRdata = st_ff.rdata;
endmodule
`default_nettype wire

// [hdl/eam_ber_window.sv]
// One bit-error monitor: counts errors over a window of whole seconds.
// Assumes errPulse and tick are single-cycle pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
module eam_ber_window
    import eam_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic errPulse,
    input wire logic clr,
    input wire eam_ber_cfg_t cfg,
    output logic cond,
    output logic raise
);
    typedef struct packed {
        logic [15:0] errCnt;
        logic [11:0] secs;
        logic cond;
        logic raise;
    } eam_bw_state_t;

    eam_bw_state_t cur_ff, nxt_cur;
    logic [27:0] prod;
    logic [15:0] limit;

    // Allowed error count for the window: two per second at the unity digit.
    always_comb begin
        prod = 28'(cfg.dur) * 28'(ERR_PER_SEC_UNITY); // RL6
        case (cfg.digit)
            4'h3: limit = 16'(prod * 28'h00003E8);
            4'h4: limit = 16'(prod * 28'h0000064);
            4'h5: limit = 16'(prod * 28'h000000A);
            4'h7: limit = 16'(prod / 28'h000000A);
            4'h8: limit = 16'(prod / 28'h0000064);
            4'h9: limit = 16'(prod / 28'h00003E8);
            default: limit = 16'(prod);
        endcase
    end

    // Window and counter update.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.raise = 1'b0;
        if (errPulse && cur_ff.errCnt != ERR_SAT) begin
            nxt_cur.errCnt = cur_ff.errCnt + 16'h0001; // RL9
        end
        if (tick) begin
            nxt_cur.secs = cur_ff.secs + 12'h001;
        end
        if (clr) begin
            nxt_cur = '0; // RL23
        end else if (nxt_cur.errCnt > limit) begin
            nxt_cur.cond = 1'b1; // RL14
            nxt_cur.raise = 1'b1;
            nxt_cur.errCnt = '0; // RL15
            nxt_cur.secs = '0;
        end else if (nxt_cur.secs >= cfg.dur) begin
            nxt_cur.cond = 1'b0; // RL16
            nxt_cur.errCnt = '0;
            nxt_cur.secs = '0;
        end
    end

    // State register.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0; // RL25
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign cond = cur_ff.cond;
    assign raise = cur_ff.raise;
endmodule
`default_nettype wire

// [hdl/eam_pkg.sv]
// Shared constants, register map and carrier types of the E1 alarm monitor.
// Assumes a single 50 MHz core clock and a one-second tick derived from it.
package eam_pkg;
    // Core clock and the one-second tick.
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_NS = 1_000_000_000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // Register offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MINOR = 8'h04;
    localparam logic [7:0] REG_MAJOR = 8'h08;
    localparam logic [7:0] REG_SLIP = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_TIME = 8'h14;
    localparam logic [7:0] REG_DATE = 8'h18;
    // Control and status bit positions.
    localparam int CTRL_SELFCLR = 0;
    localparam int CTRL_CLEAR = 1;
    localparam int STAT_BADPARAM = 3;
    // Threshold digits, durations and counter limits.
    localparam logic [3:0] DIG_MIN = 4'h3;
    localparam logic [3:0] DIG_MAX = 4'h9;
    localparam logic [3:0] DIG_UNITY = 4'h6;
    localparam logic [11:0] DUR_MAX = 12'hE10;
    localparam logic [15:0] ERR_SAT = 16'hFDE8;
    localparam logic [15:0] ERR_PER_SEC_UNITY = 16'h0002;
    localparam logic [4:0] SLIP_HRS_MAX = 5'h18;
    localparam logic [11:0] SECS_PER_HOUR = 12'hE10;
    localparam logic [4:0] HOURS_PER_DAY = 5'h18;
    localparam logic [5:0] MIN_PER_HOUR = 6'h3C;
    // Factory defaults.
    localparam logic [3:0] DEF_MINOR_DIG = 4'h6;
    localparam logic [3:0] DEF_MAJOR_DIG = 4'h5;
    localparam logic [11:0] DEF_DUR = 12'h00A;
    localparam logic [7:0] DEF_SLIP_THR = 8'h05;
    localparam logic [4:0] DEF_SLIP_HRS = 5'h02;

    typedef enum logic [2:0] {
        LVL_NONE = 3'b001,
        LVL_MINOR = 3'b010,
        LVL_MAJOR = 3'b100
    } eam_level_t;

    typedef struct packed {
        logic [3:0] digit;
        logic [11:0] dur;
    } eam_ber_cfg_t;

    typedef struct packed {
        logic [4:0] hh;
        logic [5:0] mm;
        logic [5:0] ss;
    } eam_time_t;

    typedef struct packed {
        logic [3:0] mon;
        logic [4:0] day;
        logic [6:0] yr;
    } eam_date_t;

    typedef struct packed {
        logic cleared;
        eam_level_t level;
        eam_time_t tod;
        eam_date_t date;
    } eam_log_t;

    // Shortest and longest duration allowed for each threshold digit.
    function automatic logic [11:0] eam_dur_min(input logic [3:0] d);
        case (d)
            4'h7: eam_dur_min = 12'h00A;
            4'h8: eam_dur_min = 12'h064;
            4'h9: eam_dur_min = 12'h3E8;
            default: eam_dur_min = 12'h001;
        endcase
    endfunction

    function automatic logic [11:0] eam_dur_max(input logic [3:0] d);
        case (d)
            4'h3: eam_dur_max = 12'h015;
            4'h4: eam_dur_max = 12'h0DA;
            4'h5: eam_dur_max = 12'h864;
            default: eam_dur_max = DUR_MAX;
        endcase
    endfunction
endpackage

// [tb/eam_alarm_asserts.sv]
// Checker of the alarm monitor outputs against their causes.
// Assumes it is bound into eam_alarm_monitor and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module eam_alarm_asserts
    import eam_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic alarmContact,
    input wire logic redLed,
    input wire logic lineCond,
    input wire logic chanOffHook,
    input wire logic yellowAlarm,
    input wire logic logValid,
    input wire eam_log_t logEntry,
    input wire eam_level_t alarmLevel
);
    // Core clock; quiet during reset.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Indications follow the level and log changes.
    AST_LED_CONTACT: assert property (redLed == alarmContact)
        else $error("LED and contact disagree.");
    AST_IDLE_LEVEL: assert property ((alarmLevel == LVL_NONE) == !alarmContact)
        else $error("Contact does not follow the level.");
    AST_YELLOW_COND: assert property (yellowAlarm == lineCond)
        else $error("Yellow differs from conditioning.");
    AST_COND_MAJOR: assert property (lineCond |-> alarmLevel == LVL_MAJOR)
        else $error("Conditioning without major level.");
    AST_CHAN_COND: assert property (chanOffHook |-> lineCond)
        else $error("Off-hook outside conditioning.");
    AST_RAISE_LOG: assert property ($rose(alarmContact) |->
        logValid && !logEntry.cleared && logEntry.level == alarmLevel)
        else $error("Raise not logged.");
    AST_CLEAR_LOG: assert property ($fell(alarmContact) |->
        logValid && logEntry.cleared && logEntry.level == $past(alarmLevel))
        else $error("Clear not logged.");
    AST_MANUAL_CLEAR: assert property (regWr && regAddr == REG_CTRL
        && regWdata[CTRL_CLEAR] |-> ##[2:3] !alarmContact && !lineCond)
        else $error("Manual clear left an alarm.");

    // Main scenarios reached.
    cover property ($rose(alarmContact) && alarmLevel == LVL_MINOR);
    cover property ($rose(lineCond));
    cover property ($fell(alarmContact));
endmodule
`default_nettype wire

// [tb/eam_line_model.sv]
// Carrier side model: sends counted bit-error or frame-slip pulses.
// Assumes one burst at a time; pulses every other cycle.
`timescale 1ns/1ps
`default_nettype none
module eam_line_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic slipMode,
    input wire logic [9:0] count,
    output logic bitErr,
    output logic frameSlip,
    output logic busy
);
    logic [9:0] leftFf;
    logic phaseFf;

    // Loads a burst and spaces its pulses.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            leftFf <= 10'h000;
            phaseFf <= 1'b0;
        end else if (go) begin
            leftFf <= count;
            phaseFf <= 1'b0;
        end else if (leftFf != 10'h000) begin
            phaseFf <= ~phaseFf;
            if (phaseFf) begin
                leftFf <= leftFf - 10'h001;
            end
        end
    end

    // Pulse lines stay low between bursts.
    assign bitErr = phaseFf && !slipMode;
    assign frameSlip = phaseFf && slipMode;
    assign busy = go || (leftFf != 10'h000);
endmodule
`default_nettype wire

// [tb/tb_e1_error_rate_alarm_monitor.sv]
// Self-checking bench of the alarm monitor with a carrier model.
// Assumes a short tick divider so windows last 1000 cycles.
`timescale 1ns/1ps
`default_nettype none
`define EAM_CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_e1_error_rate_alarm_monitor;
    import eam_pkg::*;
    localparam int TICK_DIV = 100;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic bitErr, frameSlip, busy;
    logic offHookSwitch = 1'b0;
    logic alarmContact, redLed, lineCond, chanOffHook, yellowAlarm, logValid;
    eam_log_t logEntry;
    eam_level_t alarmLevel;
    logic go = 1'b0;
    logic slipMode = 1'b0;
    logic [9:0] errCount = 10'h000;
    logic [31:0] seed = 32'hC9240249;
    logic [31:0] v, expMin;
    int i;
    int miscompares = 0;
    int cmp_count = 0;
    logic [15:0] corner [10] = '{16'h2005, 16'hA00A, 16'h3015, 16'h3016, 16'h7009,
        16'h900A, 16'h93E8, 16'h6000, 16'h6E10, 16'h6E11};

    // Core clock.
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    eam_alarm_monitor #(.TICK_DIV(TICK_DIV)) dut_u (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .bitErr(bitErr), .frameSlip(frameSlip),
        .offHookSwitch(offHookSwitch), .alarmContact(alarmContact), .redLed(redLed),
        .lineCond(lineCond), .chanOffHook(chanOffHook), .yellowAlarm(yellowAlarm),
        .logValid(logValid), .logEntry(logEntry), .alarmLevel(alarmLevel));

    eam_line_model line_u (.mclk(mclk), .rst(rst), .go(go), .slipMode(slipMode),
        .count(errCount), .bitErr(bitErr), .frameSlip(frameSlip), .busy(busy));

    // Xorshift source with a fixed start.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Whether a level setting is accepted.
    function automatic logic okCfg(input logic [31:0] w);
        int d, t, lo, hi;
        d = w[15:12];
        t = w[11:0];
        lo = (d == 7) ? 10 : (d == 8) ? 100 : (d == 9) ? 1000 : 1;
        hi = (d == 3) ? 21 : (d == 4) ? 218 : (d == 5) ? 2148 : 3600;
        return d >= 3 && d <= 9 && t >= lo && t <= hi;
    endfunction

    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for a level; running out ends the run.
    task automatic waitBit(ref logic s, input logic val, input int lim);
        int k;
        cmp_count++;
        for (k = 0; k < lim && s !== val; k++) @(negedge mclk);
        if (s !== val) begin
            miscompares++;
            give_verdict();
        end
    endtask

    // Bus cycles: one-cycle strobes, read data a cycle later.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic chkReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        `EAM_CHK(regRdata & m, e)
    endtask

    // Starts a carrier burst and waits for its end.
    task automatic burst(input logic s, input logic [9:0] n);
        @(posedge mclk);
        slipMode <= s;
        errCount <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        waitBit(busy, 1'b0, 2000);
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chkReg(REG_CTRL, 32'h3, 32'h1);
        chkReg(REG_MINOR, 32'hFFFF, 32'h600A);
        chkReg(REG_MAJOR, 32'hFFFF, 32'h500A);
        chkReg(REG_SLIP, 32'h1FFF, 32'h0205);
        chkReg(REG_STATUS, 32'h01FF000F, 32'h1);
        chkReg(REG_DATE, 32'hFFFF, 32'h1080);
        // Level settings: corners, then random ones.
        expMin = 32'h600A;
        for (i = 0; i < 22; i++) begin
            v = (i < 10) ? {16'h0000, corner[i]} : (rnd() & 32'h0000FFFF);
            wr(REG_STATUS, 32'h8);
            wr(REG_MINOR, v);
            if (okCfg(v)) expMin = v;
            chkReg(REG_MINOR, 32'hFFFF, expMin);
            chkReg(REG_STATUS, 32'h8, okCfg(v) ? 32'h0 : 32'h8);
        end
        wr(REG_MINOR, 32'h600A);
        wr(REG_MAJOR, 32'h500A);
        // Time wraps after one tick; a bad hour is refused.
        wr(REG_TIME, 32'h00017EFB);
        repeat (TICK_DIV) @(posedge mclk);
        chkReg(REG_TIME, 32'h1FFC0, 32'h0);
        chkReg(REG_DATE, 32'hFFFF, 32'h1100);
        wr(REG_STATUS, 32'h8);
        wr(REG_TIME, 32'h00018000);
        chkReg(REG_STATUS, 32'h8, 32'h8);
        // Twenty errors sit at the limit: no alarm.
        burst(1'b0, 10'h014);
        repeat (4) @(negedge mclk);
        `EAM_CHK(alarmContact, 1'b0)
        // Minor alarm at once, self-clear after a quiet window.
        burst(1'b0, 10'h02A);
        waitBit(alarmContact, 1'b1, 8);
        `EAM_CHK(alarmLevel, LVL_MINOR)
        `EAM_CHK(lineCond, 1'b0)
        repeat (800) @(negedge mclk);
        `EAM_CHK(alarmLevel, LVL_MINOR)
        waitBit(alarmContact, 1'b0, 3000);
        // Major alarm conditions the line.
        v = rnd();
        offHookSwitch <= v[0];
        burst(1'b0, 10'h192);
        waitBit(lineCond, 1'b1, 8);
        `EAM_CHK(alarmContact, 1'b1)
        `EAM_CHK(yellowAlarm, 1'b1)
        `EAM_CHK(chanOffHook, offHookSwitch)
        waitBit(alarmContact, 1'b0, 5000);
        // Without self-clear the indication holds until a manual clear.
        wr(REG_CTRL, 32'h0);
        burst(1'b0, 10'h192);
        waitBit(lineCond, 1'b0, 5000);
        `EAM_CHK(alarmContact, 1'b1)
        `EAM_CHK(alarmLevel, LVL_MAJOR)
        wr(REG_CTRL, 32'h2);
        repeat (4) @(negedge mclk);
        `EAM_CHK(alarmContact, 1'b0)
        `EAM_CHK(alarmLevel, LVL_NONE)
        // Slips above the threshold raise major.
        wr(REG_CTRL, 32'h1);
        wr(REG_SLIP, 32'h0101);
        burst(1'b1, 10'h001);
        repeat (4) @(negedge mclk);
        `EAM_CHK(lineCond, 1'b0)
        burst(1'b1, 10'h001);
        waitBit(lineCond, 1'b1, 8);
        chkReg(REG_STATUS, 32'h01FF0000, 32'h00020000);
        wr(REG_CTRL, 32'h3);
        repeat (4) @(negedge mclk);
        `EAM_CHK(alarmLevel, LVL_NONE)
        chkReg(REG_STATUS, 32'h01FF0000, 32'h0);
        give_verdict();
    end
endmodule

bind eam_alarm_monitor eam_alarm_asserts chk_u (.mclk(mclk),
    .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .alarmContact(alarmContact), .redLed(redLed), .lineCond(lineCond),
    .chanOffHook(chanOffHook), .yellowAlarm(yellowAlarm), .logValid(logValid),
    .logEntry(logEntry), .alarmLevel(alarmLevel));
`default_nettype wire
